/* wdt_cfg.svh */
// Constants of the watchdog block: offsets, field positions, reset values.
// Assumes inclusion by its bare name from the package and the design.
//
// How it works
// - Timeout while active and awake requests a system reset.
// - Counter advances only on ticks of the 31 kHz low-frequency oscillator.
// - Two-bit mode selects always on, off in sleep, software, always off.
// - Mode 11 is active always, sleep included; software enable ignored.
// - Mode 10 runs while awake and stops in sleep.
// - Mode 01 follows the software enable bit, awake or asleep.
// - In mode 01 sleep entry or exit never changes protection.
// - Five-bit period select sets timeout from 1 ms to 256 s.
// - Any reset returns period select to the two-second setting.
// - Resets, clear instruction, sleep in/out, osc fail, disable clear counter.
// - Counter held clear in mode 00, mode 01 disabled, mode 10 sleep.
// - Sleep entry clears the counter, which keeps counting if still active.
// - Crystal clock sleep exit holds counter clear until start-up timer ends.
// - Other clock sources clear counter once on sleep exit, no hold.
// - Timeout during sleep wakes the device instead of resetting it.
// - Timeout updates timeout and power-down flags, and the reset-cause flag when awake.
// - Changing the internal oscillator divider leaves the counter alone.
// - Code 0 is 1:32, doubling to code 18 at 2^23; above is 1:32.
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define WDT_OFF_CONTROL 8'h00
`define WDT_OFF_FLAGS 8'h04
`define WDT_OFF_IRQ_STATUS 8'h08
`define WDT_OFF_IRQ_MASK 8'h0C
`define WDT_OFF_COUNT 8'h10

// ****************************************************************
// Fields
// ****************************************************************
`define WDT_CTRL_EN_BIT 0
`define WDT_CTRL_PS_LSB 1
`define WDT_CTRL_PS_MSB 5
`define WDT_PS_RESET 5'h0B
`define WDT_PS_MAX 5'h12
`define WDT_EN_RESET 1'h0
`define WDT_BASE_SHIFT 5
`define WDT_CNT_W 23
`define WDT_IRQ_W 2
`define WDT_RESP_OKAY 2'h0
`define WDT_RESP_SLVERR 2'h2

`endif

/* wdt_pkg.sv */
// Types shared by the watchdog block.
// Assumes wdt_cfg.svh is on the include path.
`include "wdt_cfg.svh"

package wdt_pkg;

  // ****************************************************************
  // Mode field encoding
  // ****************************************************************
  typedef enum logic [1:0] {
    WDT_MODE_OFF = 2'h0,
    WDT_MODE_SOFT = 2'h1,
    WDT_MODE_AWAKE = 2'h2,
    WDT_MODE_ON = 2'h3
  } wdt_mode_type;

  // Software-visible control register
  typedef struct packed {
    logic [4:0] periodSel;
    logic softEn;
  } wdt_ctrl_type;

  // Active-low status flags kept across the reset the watchdog causes
  typedef struct packed {
    logic resetCauseN;
    logic powerdownN;
    logic timeoutN;
  } wdt_flags_type;

  // Power-state events from the sleep controller
  typedef struct packed {
    logic asleep;
    logic sleepEnter;
    logic wakeUp;
    logic ostRunning;
    logic clkIsCrystal;
  } wdt_power_type;

endpackage : wdt_pkg

/* wdt_top.sv */
// Watchdog timer with sleep wake-up, AXI4-Lite register slave.
// Assumes a 25 MHz clk, a one-cycle tick per low-frequency oscillator
// period synchronous to clk, and power events from the sleep controller.
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`include "wdt_cfg.svh"

module wdt_top #(
  parameter int CNT_W = `WDT_CNT_W
) (
  input wire logic clk,
  input wire logic resetn,
  // Core and power events
  input wire logic lowFreqOscTick,
  input wire logic [1:0] watchdogModeConfig,
  input wire logic clearWatchdogInstr,
  input wire logic sysResetIn,
  input wire logic oscFailDetect,
  input wire wdt_pkg::wdt_power_type power,
  output logic watchdogResetReq,
  output logic watchdogWakeReq,
  output wdt_pkg::wdt_flags_type flags,
  output logic irq,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Last count before timeout for a period code
  function automatic logic [CNT_W-1:0] limitOf(input logic [4:0] code);
    logic [CNT_W:0] ticks;
    ticks = '0;
    if (code > `WDT_PS_MAX) begin
      ticks[`WDT_BASE_SHIFT] = 1'b1;
    end else begin
      ticks[`WDT_BASE_SHIFT + code] = 1'b1;
    end
    limitOf = CNT_W'(ticks - (CNT_W + 1)'(1));
  endfunction : limitOf

  // True when the byte address names a mapped register
  function automatic logic isMapped(input logic [7:0] addr);
    isMapped = (addr == `WDT_OFF_CONTROL) || (addr == `WDT_OFF_FLAGS) ||
      (addr == `WDT_OFF_IRQ_STATUS) || (addr == `WDT_OFF_IRQ_MASK) ||
      (addr == `WDT_OFF_COUNT);
  endfunction : isMapped

  // ****************************************************************
  // State
  // ****************************************************************
  wdt_pkg::wdt_ctrl_type ctrl_r;
  wdt_pkg::wdt_flags_type flags_r;
  logic [CNT_W-1:0] count_r;
  logic asleepDly_r;
  logic [`WDT_IRQ_W-1:0] irqStatus_r;
  logic [`WDT_IRQ_W-1:0] irqMask_r;
  logic resetReq_r;
  logic wakeReq_r;

  logic awHeld_r;
  logic [7:0] awAddr_r;
  logic wHeld_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic bValid_r;
  logic [1:0] bResp_r;
  logic rValid_r;
  logic [31:0] rData_r;
  logic [1:0] rResp_r;

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  wdt_pkg::wdt_mode_type mode;
  logic active;
  logic wakeUpSeen;
  logic holdClear;
  logic pulseClear;
  logic timeout;

  assign mode = wdt_pkg::wdt_mode_type'(watchdogModeConfig);

  // Mode 11 ignores software enable and sleep; mode 00 is off regardless
  assign active =
    (mode == wdt_pkg::WDT_MODE_ON) ||
    ((mode == wdt_pkg::WDT_MODE_AWAKE) && !power.asleep) ||
    ((mode == wdt_pkg::WDT_MODE_SOFT) && ctrl_r.softEn);

  // Wake is also recognised from the falling edge of the sleep level
  assign wakeUpSeen = power.wakeUp || (asleepDly_r && !power.asleep);

  // Level conditions keep the counter at zero
  assign holdClear = !active ||
    (power.ostRunning && power.clkIsCrystal);

  // One-shot conditions; the divider setting is not among them
  assign pulseClear = sysResetIn ||
    clearWatchdogInstr ||
    power.sleepEnter ||
    wakeUpSeen ||
    oscFailDetect;

  // Timeout on the tick that completes the selected count
  assign timeout = active && !holdClear && !pulseClear && lowFreqOscTick &&
    (count_r == limitOf(ctrl_r.periodSel));

  // ****************************************************************
  // Counter
  // ****************************************************************
  logic [CNT_W-1:0] count_nxt;

  always_comb begin
    count_nxt = count_r;
    if (holdClear || pulseClear || timeout) begin
      count_nxt = '0;
    end else if (lowFreqOscTick) begin
      count_nxt = count_r + CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_r <= '0;
      asleepDly_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      asleepDly_r <= power.asleep;
    end
  end

  // ****************************************************************
  // Reset or wake request
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      resetReq_r <= 1'b0;
      wakeReq_r <= 1'b0;
    end else begin
      resetReq_r <= timeout && !power.asleep;
      wakeReq_r <= timeout && power.asleep;
    end
  end

  assign watchdogResetReq = resetReq_r;
  assign watchdogWakeReq = wakeReq_r;

  // ****************************************************************
  // Register write decode
  // ****************************************************************
  logic awTake;
  logic wTake;
  logic wrFire;
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic wrLow;
  logic wrCtrl;
  logic wrFlags;
  logic wrIrqStatus;
  logic wrIrqMask;

  assign s_axi_awready = !awHeld_r && !bValid_r;
  assign s_axi_wready = !wHeld_r && !bValid_r;
  assign awTake = s_axi_awvalid && s_axi_awready;
  assign wTake = s_axi_wvalid && s_axi_wready;
  assign wrFire = (awHeld_r || awTake) && (wHeld_r || wTake);
  assign wrAddr = awHeld_r ? awAddr_r : s_axi_awaddr;
  assign wrData = wHeld_r ? wData_r : s_axi_wdata;
  assign wrStrb = wHeld_r ? wStrb_r : s_axi_wstrb;
  assign wrLow = wrFire && wrStrb[0];
  assign wrCtrl = wrLow && (wrAddr == `WDT_OFF_CONTROL);
  assign wrFlags = wrLow && (wrAddr == `WDT_OFF_FLAGS);
  assign wrIrqStatus = wrLow && (wrAddr == `WDT_OFF_IRQ_STATUS);
  assign wrIrqMask = wrLow && (wrAddr == `WDT_OFF_IRQ_MASK);

  // ****************************************************************
  // Control register
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r.periodSel <= `WDT_PS_RESET;
      ctrl_r.softEn <= `WDT_EN_RESET;
    end else if (sysResetIn) begin
      ctrl_r.periodSel <= `WDT_PS_RESET;
      ctrl_r.softEn <= `WDT_EN_RESET;
    end else if (wrCtrl) begin
      ctrl_r.periodSel <= wrData[`WDT_CTRL_PS_MSB:`WDT_CTRL_PS_LSB];
      ctrl_r.softEn <= wrData[`WDT_CTRL_EN_BIT];
    end
  end

  // ****************************************************************
  // Status flags, active low, kept over a system reset
  // ****************************************************************
  wdt_pkg::wdt_flags_type flags_nxt;

  always_comb begin
    flags_nxt = flags_r;
    // Writing one re-arms a flag
    if (wrFlags) begin
      flags_nxt = flags_r | wdt_pkg::wdt_flags_type'(wrData[2:0]);
    end
    if (power.sleepEnter) begin
      flags_nxt.powerdownN = 1'b0;
      flags_nxt.timeoutN = 1'b1;
    end
    // Hardware events win over a software re-arm
    if (timeout) begin
      flags_nxt.timeoutN = 1'b0;
      flags_nxt.powerdownN = !power.asleep;
      if (!power.asleep) begin
        flags_nxt.resetCauseN = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags_r <= '1;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags = flags_r;

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  logic [`WDT_IRQ_W-1:0] irqEvents;

  assign irqEvents = {timeout && power.asleep, timeout && !power.asleep};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irqStatus_r <= '0;
      irqMask_r <= '0;
    end else begin
      irqStatus_r <= (irqStatus_r &
        ~(wrIrqStatus ? wrData[`WDT_IRQ_W-1:0] : '0)) | irqEvents;
      if (wrIrqMask) begin
        irqMask_r <= wrData[`WDT_IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irqStatus_r & irqMask_r);

  // ****************************************************************
  // Write channel
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      awHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wHeld_r <= 1'b0;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      bValid_r <= 1'b0;
      bResp_r <= `WDT_RESP_OKAY;
    end else begin
      if (wrFire) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        bValid_r <= 1'b1;
        bResp_r <= isMapped(wrAddr) ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
      end else begin
        if (awTake) begin
          awHeld_r <= 1'b1;
          awAddr_r <= s_axi_awaddr;
        end
        if (wTake) begin
          wHeld_r <= 1'b1;
          wData_r <= s_axi_wdata;
          wStrb_r <= s_axi_wstrb;
        end
        if (bValid_r && s_axi_bready) begin
          bValid_r <= 1'b0;
        end
      end
    end
  end

  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;

  // ****************************************************************
  // Read channel
  // ****************************************************************
  logic rdTake;
  logic [31:0] rdMux;

  assign s_axi_arready = !rValid_r;
  assign rdTake = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rdMux = 32'h0000_0000;
    case (s_axi_araddr)
      `WDT_OFF_CONTROL: rdMux[5:0] = ctrl_r;
      `WDT_OFF_FLAGS: rdMux[2:0] = flags_r;
      `WDT_OFF_IRQ_STATUS: rdMux[`WDT_IRQ_W-1:0] = irqStatus_r;
      `WDT_OFF_IRQ_MASK: rdMux[`WDT_IRQ_W-1:0] = irqMask_r;
      `WDT_OFF_COUNT: rdMux[CNT_W-1:0] = count_r;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rValid_r <= 1'b0;
      rData_r <= 32'h0000_0000;
      rResp_r <= `WDT_RESP_OKAY;
    end else if (rdTake) begin
      rValid_r <= 1'b1;
      rData_r <= rdMux;
      rResp_r <= isMapped(s_axi_araddr) ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
    end else if (rValid_r && s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;

endmodule : wdt_top

/* wdt_partner.sv */
// Model of the sleep controller and oscillator around the block.
// Assumes one clk; a tick every TICK_DIV cycles stands in for the slow
// oscillator, shortened so that runs stay brief.
module wdt_partner #(
  parameter int TICK_DIV = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sleepCmd,
  input wire logic holdOst,
  input wire logic wakeReq,
  output logic tick,
  output wdt_pkg::wdt_power_type power
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] div_r;
  logic cmd_r;
  logic wakeNow;
  logic enterNow;

  assign enterNow = sleepCmd && !cmd_r;
  // Watchdog wake or a dropped command ends sleep
  assign wakeNow = power.asleep && (wakeReq || !sleepCmd);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_r <= 8'h00;
      tick <= 1'b0;
      cmd_r <= 1'b0;
      power <= '0;
    end else begin
      div_r <= (div_r == 8'(TICK_DIV - 1)) ? 8'h00 : div_r + 8'h01;
      tick <= (div_r == 8'(TICK_DIV - 1));
      cmd_r <= sleepCmd;
      power.sleepEnter <= enterNow;
      power.wakeUp <= wakeNow;
      power.asleep <= enterNow || (power.asleep && !wakeNow);
      power.ostRunning <= holdOst;
      power.clkIsCrystal <= holdOst;
    end
  end
endmodule : wdt_partner

/* wdt_chk.sv */
// Assertions on the ports of the watchdog block.
// Assumes it is bound to wdt_top and sees its ports only.
module wdt_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [1:0] watchdogModeConfig,
  input wire logic clearWatchdogInstr,
  input wire logic sysResetIn,
  input wire logic oscFailDetect,
  input wire wdt_pkg::wdt_power_type power,
  input wire logic watchdogResetReq,
  input wire logic watchdogWakeReq,
  input wire wdt_pkg::wdt_flags_type flags,
  input wire logic irq,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_WAKE_ASLEEP: assert property (
    watchdogWakeReq |-> $past(power.asleep)) else $error("wake while awake");
  AST_RESET_AWAKE: assert property (
    watchdogResetReq |-> !$past(power.asleep)) else $error("reset in sleep");
  AST_MODE_OFF: assert property (
    $past(watchdogModeConfig) == 2'h0 |->
      !(watchdogResetReq || watchdogWakeReq))
    else $error("timeout in mode off");
  AST_SLEEP_OFF: assert property (
    $past(watchdogModeConfig == 2'h2 && power.asleep) |-> !watchdogWakeReq)
    else $error("wake in mode off-in-sleep");
  AST_OST_HOLD: assert property (
    $past(power.ostRunning && power.clkIsCrystal) |->
      !(watchdogResetReq || watchdogWakeReq)) else $error("timeout in hold");
  AST_CLEAR: assert property (
    clearWatchdogInstr || oscFailDetect || sysResetIn |=>
      !(watchdogResetReq || watchdogWakeReq) ##1 !watchdogResetReq)
    else $error("timeout after clear");
  AST_FLAGS_RESET: assert property (
    watchdogResetReq |-> !flags.timeoutN && !flags.resetCauseN &&
      flags.powerdownN) else $error("flags not set on reset");
  AST_FLAGS_WAKE: assert property (
    watchdogWakeReq |-> !flags.timeoutN && !flags.powerdownN)
    else $error("flags not set on wake");
  AST_PULSE: assert property (
    watchdogResetReq |=> !watchdogResetReq) else $error("reset not a pulse");
  AST_BRESP_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

  cover property (watchdogResetReq);
  cover property (watchdogWakeReq);
  cover property (irq);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule : wdt_chk

bind wdt_top wdt_chk chk_u (.clk(clk), .resetn(resetn),
  .watchdogModeConfig(watchdogModeConfig), .sysResetIn(sysResetIn),
  .clearWatchdogInstr(clearWatchdogInstr), .oscFailDetect(oscFailDetect),
  .power(power), .watchdogResetReq(watchdogResetReq), .flags(flags),
  .watchdogWakeReq(watchdogWakeReq), .irq(irq), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));

/* watchdog_timer_with_sleep_bench.sv */
// Self-checking bench for the watchdog block.
// Assumes wdt_top, wdt_partner and wdt_chk are compiled before it.
module watchdog_timer_with_sleep_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, resetn, clr, sysRst, osc, slpCmd, hold, tick, rstReq, wakeReq;
  logic irq, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] mode, bresp, rresp, rs;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] strb;
  wdt_pkg::wdt_power_type power;
  wdt_pkg::wdt_flags_type flags;
  int failCount, checksDone, cyc, n, nr, nw;
  // Row: [6:5] mode, [4] soft enable, [3] sleep, [2] start-up hold,
  // [1] reset expected, [0] wake expected
  logic [6:0] rows [9] = '{7'h62, 7'h69, 7'h42, 7'h48, 7'h32, 7'h39,
    7'h20, 7'h10, 7'h64};
  logic [31:0] psTab [3] = '{32'h0, 32'h1, 32'h13};
  logic [31:0] nTab [3] = '{32'h20, 32'h40, 32'h20};

  wdt_top dut_u (.clk(clk), .resetn(resetn), .lowFreqOscTick(tick),
    .watchdogModeConfig(mode), .clearWatchdogInstr(clr), .sysResetIn(sysRst),
    .oscFailDetect(osc), .power(power), .watchdogResetReq(rstReq),
    .watchdogWakeReq(wakeReq), .flags(flags), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  wdt_partner part_u (.clk(clk), .resetn(resetn), .sleepCmd(slpCmd),
    .holdOst(hold), .wakeReq(wakeReq), .tick(tick), .power(power));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task conclude;
    $display("Checks %0d, errors %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      failCount++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask : axw

  task axr(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axr

  task pulseClr;
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask : pulseClr

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failCount++;
      conclude();
    end
  end

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    {resetn, clr, sysRst, osc, slpCmd, hold} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    mode = 2'h3;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    strb = 4'hF;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    axr(8'h00);
    chk(rd, 32'h16);
    chk(rs, 2'h0);
    axr(8'h04);
    chk(rd, 32'h7);
    axr(8'h20);
    chk(rs, 2'h2);
    chk(rd, 32'h0);
    axw(8'h20, 32'h1);
    chk(rs, 2'h2);
    for (int i = 0; i < 9; i++) begin
      mode <= rows[i][6:5];
      axw(8'h00, {31'h0, rows[i][4]});
      hold <= rows[i][2];
      pulseClr();
      slpCmd <= rows[i][3];
      nr = 0;
      nw = 0;
      repeat (200) begin
        @(negedge clk);
        nr += rstReq;
        nw += wakeReq;
      end
      chk(nr, rows[i][1]);
      chk(nw, rows[i][0]);
      @(posedge clk);
      slpCmd <= 1'b0;
      hold <= 1'b0;
    end
    for (int k = 0; k < 3; k++) begin
      axw(8'h04, 32'h5);
      axw(8'h00, psTab[k] << 1);
      pulseClr();
      n = 0;
      do begin
        @(negedge clk);
        n += tick;
      end while (!rstReq && n < 300);
      chk(n, nTab[k]);
      axr(8'h04);
      chk(rd, 32'h2);
    end
    pulseClr();
    repeat (80) @(posedge clk);
    osc <= 1'b1;
    @(posedge clk);
    osc <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n += tick;
    end while (!rstReq && n < 300);
    chk(n, 32'h20);
    mode <= 2'h0;
    axr(8'h10);
    chk(rd, 32'h0);
    axw(8'h0C, 32'h1);
    @(negedge clk);
    chk(irq, 1'b1);
    axw(8'h0C, 32'h0);
    @(negedge clk);
    chk(irq, 1'b0);
    axw(8'h0C, 32'h1);
    axw(8'h08, 32'h3);
    chk(rs, 2'h0);
    @(negedge clk);
    chk(irq, 1'b0);
    axw(8'h00, 32'h0);
    strb <= 4'h0;
    axw(8'h00, 32'h2);
    strb <= 4'hF;
    axr(8'h00);
    chk(rd, 32'h0);
    sysRst <= 1'b1;
    @(posedge clk);
    sysRst <= 1'b0;
    axr(8'h00);
    chk(rd, 32'h16);
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    axr(8'h04);
    chk(rd, 32'h7);
    conclude();
  end
endmodule : watchdog_timer_with_sleep_bench
